// ### verilog/tmctl_pkg.sv
// constants for the upper timer control block
`default_nettype none
package tmctl_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h17;
    localparam logic [7:0] IDX_PERIOD = 8'h19;
    localparam logic [7:0] IDX_PWIDTH = 8'h1b;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    localparam logic [7:0] IDX_MASK = 8'h21;
    localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] ADDR_PERIOD = {IDX_PERIOD, 2'b00};
    localparam logic [9:0] ADDR_PWIDTH = {IDX_PWIDTH, 2'b00};
    localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [9:0] ADDR_MASK = {IDX_MASK, 2'b00};
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'hff;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    // control field positions
    localparam int FF_BIT = 7;
    localparam int CS_MSB = 6;
    localparam int CS_LSB = 4;
    localparam int START_BIT = 3;
    localparam int MODE_MSB = 2;
    localparam int MODE_LSB = 0;
    localparam int STAT_MATCH_BIT = 0;
    // mode codes
    localparam logic [2:0] MODE_TIMER8 = 3'h0;
    localparam logic [2:0] MODE_PDO8 = 3'h1;
    localparam logic [2:0] MODE_PWM8 = 3'h2;
    localparam logic [2:0] MODE_RSVD = 3'h3;
    localparam logic [2:0] MODE_T16 = 3'h4;
    localparam logic [2:0] MODE_WARMUP = 3'h5;
    localparam logic [2:0] MODE_PWM16 = 3'h6;
    localparam logic [2:0] MODE_PPG16 = 3'h7;
    // clock select codes
    localparam logic [2:0] CS_DIV11 = 3'h0;
    localparam logic [2:0] CS_DIV7 = 3'h1;
    localparam logic [2:0] CS_DIV5 = 3'h2;
    localparam logic [2:0] CS_DIV3 = 3'h3;
    localparam logic [2:0] CS_LF = 3'h4;
    localparam logic [2:0] CS_DIV1 = 3'h5;
    localparam logic [2:0] CS_HF = 3'h6;
    localparam logic [2:0] CS_PIN = 3'h7;
    // pin level must persist this many cycles
    localparam logic [1:0] PIN_STABLE_CYC = 2'h2;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### verilog/tmctl_pin_filter.sv
// timer input pin synchroniser, level filter and falling edge detect
`default_nettype none
module tmctl_pin_filter (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pin side
    input wire logic pin_in,
    // falling edge pulse
    output logic fall_pulse
);
    logic sync1_r, sync2_r, level_r, level_nxt, fall_r, fall_nxt;
    logic [1:0] run_r, run_nxt;

    always_comb begin
        level_nxt = level_r;
        run_nxt = run_r;
        fall_nxt = 1'b0;
        if (sync2_r == level_r) begin
            run_nxt = 2'h0;
        end else if (run_r + 2'h1 >= tmctl_pkg::PIN_STABLE_CYC) begin
            // new level held long enough
            level_nxt = sync2_r;
            run_nxt = 2'h0;
            fall_nxt = level_r & ~sync2_r;
        end else begin
            run_nxt = run_r + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            level_r <= 1'b1;
            run_r <= 2'h0;
            fall_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            level_r <= level_nxt;
            run_r <= run_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign fall_pulse = fall_r;
endmodule
`default_nettype wire

// ### verilog/tmctl_top.sv
// upper timer control, compare registers and source select over axi4-lite
// What this block does
// - control register resets zero, fields ff/clk/start/mode
// - period and width compares reset to ones
// - normal clock codes pick prescaled taps, the fast clock itself (110) or pin
// - divider bit or slow mode gives the slow tap on code 000
// - start low stops and clears; high counts in timer mode
// - upper mode codes pick sixteen-bit functions
// - lower mode codes eight-bit functions; 011 reserved
// - sixteen-bit modes clock from lower overflow
// - lower select clocks pair; this start/ff control
// - starting write may load new fields too
// - timer mode counts, matches period, interrupts, clears
// - event count on filtered falling pin edge
//
// The AXI4-Lite slave port was chosen for this implementation.
`default_nettype none
module tmctl_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [9:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [9:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // prescaler taps, one-cycle pulses
    input wire logic hf_div11_tick,
    input wire logic hf_div7_tick,
    input wire logic hf_div5_tick,
    input wire logic hf_div3_tick,
    input wire logic hf_div1_tick,
    input wire logic lf_tick,
    input wire logic lf_div3_tick,
    // operating state of the chip
    input wire logic divider_select_bit,
    input wire logic slow_mode,
    // lower timer link
    input wire logic lower_overflow,
    input wire logic [2:0] lower_mode_field,
    // external timer pin
    input wire logic timer_pin,
    // timer outputs
    output logic output_flipflop,
    output logic timer_running,
    output logic source_tick,
    output logic [6:0] mode_decode,
    output logic [7:0] upper_count,
    output logic [7:0] pulse_width_level,
    output logic cascade_ok,
    output logic irq
);
    logic [7:0] ctrl_r, ctrl_nxt, period_r, period_nxt, pwidth_r, pwidth_nxt;
    logic [7:0] status_r, status_nxt, mask_r, mask_nxt, cnt_r, cnt_nxt;
    logic [6:0] mdec_r, mdec_nxt;
    logic ff_r, ff_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wr_go, rd_go, match_evt, pin_fall, slow_sel;
    logic [2:0] cs, mode;
    // value a status read leaves behind
    localparam logic [7:0] STATUS_CLR = 8'h00;

    tmctl_pin_filter tmctl_pin_filter_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(timer_pin),
        .fall_pulse(pin_fall)
    );

    assign cs = ctrl_r[tmctl_pkg::CS_MSB:tmctl_pkg::CS_LSB];
    assign mode = ctrl_r[tmctl_pkg::MODE_MSB:tmctl_pkg::MODE_LSB];
    assign slow_sel = divider_select_bit | slow_mode;

    // source clock select
    always_comb begin
        source_tick = 1'b0;
        if (mode[2]) begin
            source_tick = lower_overflow;
        end else begin
            unique case (cs)
                tmctl_pkg::CS_DIV11: source_tick = slow_sel ? lf_div3_tick : hf_div11_tick;
                tmctl_pkg::CS_DIV7: source_tick = !slow_mode & hf_div7_tick;
                tmctl_pkg::CS_DIV5: source_tick = !slow_mode & hf_div5_tick;
                tmctl_pkg::CS_DIV3: source_tick = !slow_mode & hf_div3_tick;
                tmctl_pkg::CS_LF: source_tick = lf_tick;
                tmctl_pkg::CS_DIV1: source_tick = !slow_mode & hf_div1_tick;
                tmctl_pkg::CS_HF: source_tick = !slow_mode;
                tmctl_pkg::CS_PIN: source_tick = pin_fall;
            endcase
        end
    end

    // bus handshakes
    assign awready = awvalid & wvalid & !bvalid_r;
    assign wready = awready;
    assign wr_go = awready;
    assign arready = !rvalid_r;
    assign rd_go = arvalid & arready;

    // counter and match
    always_comb begin
        cnt_nxt = cnt_r;
        match_evt = 1'b0;
        if (!ctrl_r[tmctl_pkg::START_BIT]) begin
            cnt_nxt = 8'h00;
        end else if (mode == tmctl_pkg::MODE_TIMER8 && source_tick) begin
            if (cnt_r + 8'h01 == period_r) begin
                cnt_nxt = 8'h00;
                match_evt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    // register file, interrupt status and mode decode
    always_comb begin
        ctrl_nxt = ctrl_r;
        period_nxt = period_r;
        pwidth_nxt = pwidth_r;
        mask_nxt = mask_r;
        status_nxt = status_r;
        bvalid_nxt = bvalid_r & !bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r & !rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = tmctl_pkg::RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            unique case (araddr)
                tmctl_pkg::ADDR_CTRL: rdata_nxt[7:0] = ctrl_r;
                tmctl_pkg::ADDR_PERIOD: rdata_nxt[7:0] = period_r;
                tmctl_pkg::ADDR_PWIDTH: rdata_nxt[7:0] = pwidth_r;
                tmctl_pkg::ADDR_MASK: rdata_nxt[7:0] = mask_r;
                tmctl_pkg::ADDR_STATUS: begin
                    rdata_nxt[7:0] = status_r;
                    status_nxt = STATUS_CLR;
                end
                default: rresp_nxt = tmctl_pkg::RESP_SLVERR;
            endcase
        end
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = tmctl_pkg::RESP_OKAY;
            unique case (awaddr)
                // new fields land with the start bit
                tmctl_pkg::ADDR_CTRL: if (wstrb[0]) ctrl_nxt = wdata[7:0];
                tmctl_pkg::ADDR_PERIOD: if (wstrb[0]) period_nxt = wdata[7:0];
                tmctl_pkg::ADDR_PWIDTH: if (wstrb[0]) pwidth_nxt = wdata[7:0];
                tmctl_pkg::ADDR_MASK: if (wstrb[0]) mask_nxt = wdata[7:0];
                tmctl_pkg::ADDR_STATUS: ;
                default: bresp_nxt = tmctl_pkg::RESP_SLVERR;
            endcase
        end
        // set wins over read clear
        if (match_evt) begin
            status_nxt[tmctl_pkg::STAT_MATCH_BIT] = 1'b1;
        end
        ff_nxt = ctrl_nxt[tmctl_pkg::FF_BIT];
        mdec_nxt = 7'h00;
        unique case (ctrl_nxt[tmctl_pkg::MODE_MSB:tmctl_pkg::MODE_LSB])
            tmctl_pkg::MODE_TIMER8: mdec_nxt[0] = 1'b1;
            tmctl_pkg::MODE_PDO8: mdec_nxt[1] = 1'b1;
            tmctl_pkg::MODE_PWM8: mdec_nxt[2] = 1'b1;
            tmctl_pkg::MODE_RSVD: mdec_nxt = 7'h00;
            tmctl_pkg::MODE_T16: mdec_nxt[3] = 1'b1;
            tmctl_pkg::MODE_WARMUP: mdec_nxt[4] = 1'b1;
            tmctl_pkg::MODE_PWM16: mdec_nxt[5] = 1'b1;
            tmctl_pkg::MODE_PPG16: mdec_nxt[6] = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= tmctl_pkg::CTRL_RST;
            period_r <= tmctl_pkg::CMP_RST;
            pwidth_r <= tmctl_pkg::CMP_RST;
            status_r <= tmctl_pkg::STATUS_RST;
            mask_r <= tmctl_pkg::MASK_RST;
            cnt_r <= 8'h00;
            mdec_r <= 7'h01;
            ff_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= tmctl_pkg::RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= tmctl_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            period_r <= period_nxt;
            pwidth_r <= pwidth_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            cnt_r <= cnt_nxt;
            mdec_r <= mdec_nxt;
            ff_r <= ff_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign output_flipflop = ff_r;
    assign timer_running = ctrl_r[tmctl_pkg::START_BIT];
    assign mode_decode = mdec_r;
    assign upper_count = cnt_r;
    assign pulse_width_level = pwidth_r;
    // in sixteen-bit modes cascade valid only with lower mode 011
    assign cascade_ok = !mode[2] | (lower_mode_field == tmctl_pkg::MODE_RSVD);
    assign irq = |(status_r & mask_r);

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ctrl_reset;
        $rose(aresetn) |-> ctrl_r == 8'h00 && !output_flipflop && !timer_running;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not zero after reset");

    property p_cmp_reset;
        $rose(aresetn) |-> period_r == 8'hff && pwidth_r == 8'hff;
    endproperty
    a_cmp_reset: assert property (p_cmp_reset) else $error("compare not ones after reset");

    property p_stop_clears;
        !timer_running |=> upper_count == 8'h00;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("counter not cleared on stop");

    property p_cascade_src;
        mode[2] |-> source_tick == lower_overflow;
    endproperty
    a_cascade_src: assert property (p_cascade_src) else $error("16-bit source not overflow");

    property p_fast_src;
        !mode[2] && !slow_mode && cs == 3'h6 |-> source_tick;
    endproperty
    a_fast_src: assert property (p_fast_src) else $error("fast clock not selected");

    property p_slow_src;
        !mode[2] && cs == 3'h0 && slow_sel |-> source_tick == lf_div3_tick;
    endproperty
    a_slow_src: assert property (p_slow_src) else $error("slow tap not selected");

    property p_slow_invalid;
        !mode[2] && slow_mode && cs == 3'h1 |-> !source_tick;
    endproperty
    a_slow_invalid: assert property (p_slow_invalid) else $error("invalid slow code ticks");

    property p_match;
        timer_running && mode == 3'h0 && source_tick && cnt_r + 8'h01 == period_r
            |=> upper_count == 8'h00 && status_r[0] ##1 1;
    endproperty
    a_match: assert property (p_match) else $error("match did not clear and flag");

    property p_pin_src;
        !mode[2] && cs == 3'h7 |-> source_tick == pin_fall;
    endproperty
    a_pin_src: assert property (p_pin_src) else $error("pin edge not selected");

    property p_start_load;
        wr_go && awaddr == 10'h05c && wstrb[0] && !timer_running && wdata[3]
            |=> ctrl_r == $past(wdata[7:0]) && output_flipflop == $past(wdata[7]);
    endproperty
    a_start_load: assert property (p_start_load) else $error("start write lost fields");

    property p_reserved;
        wr_go && awaddr == 10'h05c && wstrb[0] && wdata[2:0] == 3'h3 |=> mode_decode == 7'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode decoded");

    property p_mode16;
        wr_go && awaddr == 10'h05c && wstrb[0] && wdata[2:0] == 3'h7 |=> mode_decode == 7'h40;
    endproperty
    a_mode16: assert property (p_mode16) else $error("ppg mode not decoded");

    c_match: cover property (match_evt);
    c_irq: cover property (irq);
    c_pin: cover property (pin_fall && timer_running);
    c_cascade: cover property (mode[2] && lower_overflow && timer_running);
endmodule
`default_nettype wire

// ### verif/tmctl_top_test.sv
// self-checking bench for the upper timer control block
`default_nettype none
module tmctl_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [9:0] awaddr = 10'h000;
    logic [9:0] araddr = 10'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [6:0] taps = 7'h00;
    logic [3:0] strb = 4'h1;
    logic divsel = 1'b0;
    logic slow = 1'b0;
    logic lower_ovf = 1'b0;
    logic [2:0] lower_mode = 3'h0;
    logic pin = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, output_flipflop, timer_running;
    logic source_tick, cascade_ok, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd_data;
    logic [6:0] mode_decode, exp_dec;
    logic [7:0] upper_count, pulse_width_level;
    int n_fail = 0;
    int compares = 0;

    always #50 aclk = ~aclk;

    tmctl_top tmctl_top_inst (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
        .wdata, .wstrb(strb), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .hf_div11_tick(taps[0]), .hf_div7_tick(taps[1]), .hf_div5_tick(taps[2]),
        .hf_div3_tick(taps[3]), .lf_tick(taps[4]), .hf_div1_tick(taps[5]),
        .lf_div3_tick(taps[6]), .divider_select_bit(divsel), .slow_mode(slow),
        .lower_overflow(lower_ovf), .lower_mode_field(lower_mode), .timer_pin(pin),
        .output_flipflop, .timer_running, .source_tick, .mode_decode, .upper_count,
        .pulse_width_level, .cascade_ok, .irq
    );

    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // write one register, hold each channel until taken
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        // bready stays high so a following call never re-raises it in one step
        @(posedge aclk);
    endtask

    task automatic rd(input logic [9:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        rd_data = rdata;
        resp = rresp;
        // rready stays high so a following call never re-raises it in one step
        @(posedge aclk);
    endtask

    task automatic rdc(input string nm, input logic [9:0] a, input logic [31:0] exp);
        rd(a);
        chk(nm, exp, rd_data);
        chk("rresp", 32'(tmctl_pkg::RESP_OKAY), resp);
    endtask

    // one-cycle source pulse, tick looked at in that cycle
    task automatic src(input logic [6:0] tp, input logic lo, input logic e);
        taps <= tp;
        lower_ovf <= lo;
        @(negedge aclk);
        chk("source_tick", e, source_tick);
        @(posedge aclk);
        taps <= 7'h00;
        lower_ovf <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic pinlvl(input logic v, input int n);
        pin <= v;
        repeat (n) @(posedge aclk);
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        results();
    end

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc("ctrl", tmctl_pkg::ADDR_CTRL, 32'h00000000);
        rdc("period", tmctl_pkg::ADDR_PERIOD, 32'h000000ff);
        rdc("width", tmctl_pkg::ADDR_PWIDTH, 32'h000000ff);
        rdc("status", tmctl_pkg::ADDR_STATUS, 32'h00000000);
        rdc("mask", tmctl_pkg::ADDR_MASK, 32'h00000000);
        chk("mode_decode", 32'h01, mode_decode);
        wr(tmctl_pkg::ADDR_PERIOD, 8'h5a);
        rdc("period", tmctl_pkg::ADDR_PERIOD, 32'h0000005a);
        wr(tmctl_pkg::ADDR_PWIDTH, 8'ha5);
        rdc("width", tmctl_pkg::ADDR_PWIDTH, 32'h000000a5);
        chk("pulse_width_level", 32'ha5, pulse_width_level);
        // low byte strobe off: answered okay, nothing stored
        strb <= 4'h0;
        wr(tmctl_pkg::ADDR_PERIOD, 8'h33);
        chk("bresp", 32'(tmctl_pkg::RESP_OKAY), resp);
        strb <= 4'h1;
        rdc("period", tmctl_pkg::ADDR_PERIOD, 32'h0000005a);
        wr(10'h3fc, 8'h11);
        chk("bresp", 32'(tmctl_pkg::RESP_SLVERR), resp);
        rd(10'h3fc);
        chk("rresp", 32'(tmctl_pkg::RESP_SLVERR), resp);
        // every mode code, decode and cascade qualifier
        for (int m = 0; m < 8; m++) begin
            wr(tmctl_pkg::ADDR_CTRL, 8'(m));
            exp_dec = (m == 3) ? 7'h00 : 7'(1 << ((m < 3) ? m : m - 1));
            chk("mode_decode", exp_dec, mode_decode);
            chk("cascade_ok", m < 4, cascade_ok);
        end
        lower_mode <= 3'h3;
        @(negedge aclk);
        chk("cascade_ok", 32'h1, cascade_ok);
        @(posedge aclk);
        // clock-select codes 0 to 6 in normal operation
        for (int c = 0; c < 6; c++) begin
            wr(tmctl_pkg::ADDR_CTRL, {1'b0, 3'(c), 4'h2});
            src(7'(1 << c), 1'b0, 1'b1);
            src(7'h7f ^ 7'(1 << c), 1'b1, 1'b0);
        end
        wr(tmctl_pkg::ADDR_CTRL, 8'h62);
        src(7'h00, 1'b0, 1'b1);
        divsel <= 1'b1;
        wr(tmctl_pkg::ADDR_CTRL, 8'h00);
        src(7'h01, 1'b0, 1'b0);
        src(7'h40, 1'b0, 1'b1);
        divsel <= 1'b0;
        slow <= 1'b1;
        wr(tmctl_pkg::ADDR_CTRL, 8'h10);
        src(7'h02, 1'b0, 1'b0);
        wr(tmctl_pkg::ADDR_CTRL, 8'h40);
        src(7'h10, 1'b0, 1'b1);
        slow <= 1'b0;
        wr(tmctl_pkg::ADDR_CTRL, 8'h04);
        src(7'h01, 1'b0, 1'b0);
        src(7'h00, 1'b1, 1'b1);
        // timer mode on a tick every cycle, period three
        wr(tmctl_pkg::ADDR_PERIOD, 8'h03);
        wr(tmctl_pkg::ADDR_MASK, 8'h01);
        // prescaled tap held high gives a tick every cycle
        taps <= 7'h01;
        wr(tmctl_pkg::ADDR_CTRL, 8'h88);
        chk("output_flipflop", 32'h1, output_flipflop);
        chk("timer_running", 32'h1, timer_running);
        chk("mode_decode", 32'h01, mode_decode);
        rdc("ctrl", tmctl_pkg::ADDR_CTRL, 32'h00000088);
        repeat (12) begin
            @(negedge aclk);
            chk("count_below_period", 32'h1, upper_count < 8'h03);
        end
        chk("irq", 32'h1, irq);
        @(posedge aclk);
        taps <= 7'h00;
        wr(tmctl_pkg::ADDR_CTRL, 8'h80);
        repeat (4) @(posedge aclk);
        chk("upper_count", 32'h0, upper_count);
        chk("timer_running", 32'h0, timer_running);
        wr(tmctl_pkg::ADDR_MASK, 8'h00);
        chk("irq", 32'h0, irq);
        wr(tmctl_pkg::ADDR_MASK, 8'h01);
        chk("irq", 32'h1, irq);
        rdc("status", tmctl_pkg::ADDR_STATUS, 32'h00000001);
        rdc("status", tmctl_pkg::ADDR_STATUS, 32'h00000000);
        chk("irq", 32'h0, irq);
        // event counting on filtered falling pin edges, period two
        wr(tmctl_pkg::ADDR_PERIOD, 8'h02);
        wr(tmctl_pkg::ADDR_CTRL, 8'h78);
        pinlvl(1'b0, 1);
        pinlvl(1'b1, 10);
        pinlvl(1'b0, 10);
        pinlvl(1'b1, 10);
        rdc("status", tmctl_pkg::ADDR_STATUS, 32'h00000000);
        pinlvl(1'b0, 10);
        pinlvl(1'b1, 10);
        rdc("status", tmctl_pkg::ADDR_STATUS, 32'h00000001);
        // reset in mid-run restores control, compares and mode decode
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc("ctrl", tmctl_pkg::ADDR_CTRL, 32'h00000000);
        rdc("period", tmctl_pkg::ADDR_PERIOD, 32'h000000ff);
        rdc("width", tmctl_pkg::ADDR_PWIDTH, 32'h000000ff);
        chk("mode_decode", 32'h01, mode_decode);
        results();
    end
endmodule
`default_nettype wire
